// ==== hw/spl_pkg.sv ====
// Package: constants and types of the sector protection lock logic
`default_nettype none
package spl_pkg;

  // ----------------------------------------------------------------
  // Sector geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_SECTORS = 16;
  localparam int unsigned SEC_W       = 4;
  localparam int unsigned SEC_LSB     = 16;
  localparam int unsigned ADDR_W      = 32;

  // ----------------------------------------------------------------
  // Opcodes and write-data decode
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ_STATUS  = 8'h05;
  localparam logic [7:0] OP_PROTECT      = 8'h36;
  localparam logic [7:0] OP_UNPROTECT    = 8'h39;
  localparam logic [7:0] OP_READ_PROT    = 8'h3c;

  localparam int unsigned LOCK_BIT    = 7;
  localparam int unsigned GLOB_MSB    = 5;
  localparam int unsigned GLOB_LSB    = 2;
  localparam logic [3:0]  GLOB_UNPROT = 4'h0;
  localparam logic [3:0]  GLOB_PROT   = 4'hf;

  // ----------------------------------------------------------------
  // Status byte layout on read
  // ----------------------------------------------------------------
  localparam int unsigned STAT_WP_BIT  = 4;
  localparam int unsigned STAT_SUM_LSB = 2;
  localparam logic [1:0]  SUM_NONE     = 2'h0;
  localparam logic [1:0]  SUM_SOME     = 2'h1;
  localparam logic [1:0]  SUM_ALL      = 2'h3;

  // ----------------------------------------------------------------
  // Frame counters and reset values
  // ----------------------------------------------------------------
  localparam logic [5:0]  OP_LAST_BIT   = 6'h07;
  localparam logic [5:0]  ADDR_LAST_BIT = 6'h1f;
  localparam logic [5:0]  DATA_LAST_BIT = 6'h07;
  localparam logic [2:0]  OUT_MSB       = 3'h7;
  localparam logic        LOCK_RST      = 1'b0;
  localparam logic [NUM_SECTORS-1:0] PROT_RST = '1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_WSR   = 2'b00,
    CMD_PROT  = 2'b01,
    CMD_UNPROT = 2'b10,
    CMD_NONE  = 2'b11
  } spl_cmd_e;

  typedef enum logic [2:0] {
    LS_OPCODE = 3'b000,
    LS_ADDR   = 3'b001,
    LS_DATA   = 3'b010,
    LS_RDPROT = 3'b011,
    LS_RDSTAT = 3'b100,
    LS_IGNORE = 3'b101
  } spl_link_e;

  typedef struct packed {
    spl_cmd_e         kind;
    logic [7:0]       data;
    logic [SEC_W-1:0] sector;
  } spl_cmd_s;

endpackage
`default_nettype wire

// ==== hw/spl_lock.sv ====
// Sector protection and locking logic with serial command link
`default_nettype none
module spl_lock (
  input  wire logic                         clk,              // System clock, 50 MHz
  input  wire logic                         rst,              // Async reset, active high
  input  wire logic                         sck,              // Link serial clock
  input  wire logic                         cs_n,             // Link chip select, low
  input  wire logic                         si,               // Link serial data in
  output logic                              so_o,             // Link serial data out
  output logic                              so_oe,            // Link output enable
  input  wire logic                         wp_n,             // Write-protect pin, low
  input  wire logic                         octal_mode,       // Octal mode, pin disabled
  output logic [spl_pkg::NUM_SECTORS-1:0]   sector_prot,      // Per-sector protection
  output logic                              protection_lock_bit, // Lock bit
  output logic                              hw_lock,          // Hardware lock active
  output logic [1:0]                        software_protection_summary, // All/some/none
  output logic [7:0]                        status_byte       // Status as read by host
);

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] prot_summary(input logic [spl_pkg::NUM_SECTORS-1:0] v);
    if (&v) begin
      return spl_pkg::SUM_ALL;
    end else if (|v) begin
      return spl_pkg::SUM_SOME;
    end else begin
      return spl_pkg::SUM_NONE;
    end
  endfunction

  function automatic logic [spl_pkg::SEC_W-1:0] addr_sector(
    input logic [spl_pkg::ADDR_W-1:0] a
  );
    return a[spl_pkg::SEC_LSB +: spl_pkg::SEC_W];
  endfunction

  // Frame state clears the instant chip select rises
  logic link_rst;
  assign link_rst = rst | cs_n;

  // ----------------------------------------------------------------
  // Link domain: command deserialiser
  // ----------------------------------------------------------------
  spl_pkg::spl_link_e              ls_q;
  logic [5:0]                      bit_cnt_q;
  logic [spl_pkg::ADDR_W-1:0]      shift_q;
  logic [7:0]                      op_q;
  logic [spl_pkg::SEC_W-1:0]       rd_sector_q;
  logic [spl_pkg::ADDR_W-1:0]      shift_next;
  spl_pkg::spl_cmd_s               req_d;
  logic                            req_fire;

  assign shift_next = {shift_q[spl_pkg::ADDR_W-2:0], si};

  always_comb begin
    req_fire = 1'b0;
    req_d    = '{kind: spl_pkg::CMD_NONE, data: 8'h00, sector: '0};
    if (ls_q == spl_pkg::LS_DATA && bit_cnt_q == spl_pkg::DATA_LAST_BIT) begin
      req_fire    = 1'b1;
      req_d.kind  = spl_pkg::CMD_WSR;
      req_d.data  = shift_next[7:0];
    end else if (ls_q == spl_pkg::LS_ADDR && bit_cnt_q == spl_pkg::ADDR_LAST_BIT &&
                 op_q != spl_pkg::OP_READ_PROT) begin
      req_fire     = 1'b1;
      req_d.kind   = (op_q == spl_pkg::OP_PROTECT) ? spl_pkg::CMD_PROT : spl_pkg::CMD_UNPROT;
      req_d.sector = addr_sector(shift_next);
    end
  end

  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      ls_q        <= spl_pkg::LS_OPCODE;
      bit_cnt_q   <= 6'h00;
      shift_q     <= '0;
      op_q        <= 8'h00;
      rd_sector_q <= '0;
    end else begin
      shift_q   <= shift_next;
      bit_cnt_q <= bit_cnt_q + 6'h01;
      case (ls_q)
        spl_pkg::LS_OPCODE: begin
          if (bit_cnt_q == spl_pkg::OP_LAST_BIT) begin
            bit_cnt_q <= 6'h00;
            op_q      <= shift_next[7:0];
            case (shift_next[7:0])
              spl_pkg::OP_READ_PROT,
              spl_pkg::OP_PROTECT,
              spl_pkg::OP_UNPROTECT:   ls_q <= spl_pkg::LS_ADDR;
              spl_pkg::OP_WRITE_STATUS: ls_q <= spl_pkg::LS_DATA;
              spl_pkg::OP_READ_STATUS:  ls_q <= spl_pkg::LS_RDSTAT;
              default:                  ls_q <= spl_pkg::LS_IGNORE;
            endcase
          end
        end
        spl_pkg::LS_ADDR: begin
          if (bit_cnt_q == spl_pkg::ADDR_LAST_BIT) begin
            bit_cnt_q   <= 6'h00;
            rd_sector_q <= addr_sector(shift_next);
            ls_q        <= (op_q == spl_pkg::OP_READ_PROT) ? spl_pkg::LS_RDPROT
                                                           : spl_pkg::LS_IGNORE;
          end
        end
        spl_pkg::LS_DATA: begin
          if (bit_cnt_q == spl_pkg::DATA_LAST_BIT) begin
            bit_cnt_q <= 6'h00;
            ls_q      <= spl_pkg::LS_IGNORE;
          end
        end
        spl_pkg::LS_RDPROT,
        spl_pkg::LS_RDSTAT,
        spl_pkg::LS_IGNORE: begin
          bit_cnt_q <= 6'h00;
        end
        default: begin
          ls_q <= spl_pkg::LS_IGNORE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Link domain: request hand-off, survives the end of the frame
  // ----------------------------------------------------------------
  // Payload is held steady until the next request, so the toggle
  // alone needs synchronising on the system side.
  spl_pkg::spl_cmd_s req_q;
  logic              req_tgl_q;

  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      req_q     <= '{kind: spl_pkg::CMD_NONE, data: 8'h00, sector: '0};
      req_tgl_q <= 1'b0;
    end else if (req_fire) begin
      req_q     <= req_d;
      req_tgl_q <= ~req_tgl_q;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: state brought over from the system clock
  // ----------------------------------------------------------------
  // The clock only runs in frames; opcode and address give it 40
  // edges to refresh before the protection bit is driven out, while
  // the status byte follows the 8 opcode edges alone.
  logic [spl_pkg::NUM_SECTORS-1:0] prot_s1_q;
  logic [spl_pkg::NUM_SECTORS-1:0] prot_s2_q;
  logic [7:0]                      stat_s1_q;
  logic [7:0]                      stat_s2_q;

  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      prot_s1_q <= spl_pkg::PROT_RST;
      prot_s2_q <= spl_pkg::PROT_RST;
      stat_s1_q <= 8'h00;
      stat_s2_q <= 8'h00;
    end else begin
      prot_s1_q <= sector_prot;
      prot_s2_q <= prot_s1_q;
      stat_s1_q <= status_byte;
      stat_s2_q <= stat_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: output on the falling edge, MSB first
  // ----------------------------------------------------------------
  logic [2:0] out_idx_q;
  logic       so_q;

  always_ff @(negedge sck or posedge link_rst) begin
    if (link_rst) begin
      out_idx_q <= spl_pkg::OUT_MSB;
      so_q      <= 1'b0;
    end else begin
      case (ls_q)
        spl_pkg::LS_RDPROT: begin
          // Every bit of the byte is the stored bit, pin not involved
          so_q <= prot_s2_q[rd_sector_q];
        end
        spl_pkg::LS_RDSTAT: begin
          so_q      <= stat_s2_q[out_idx_q];
          out_idx_q <= out_idx_q - 3'h1;
        end
        default: begin
          so_q      <= 1'b0;
          out_idx_q <= spl_pkg::OUT_MSB;
        end
      endcase
    end
  end

  assign so_o  = so_q;
  assign so_oe = (ls_q == spl_pkg::LS_RDPROT) || (ls_q == spl_pkg::LS_RDSTAT);

  // ----------------------------------------------------------------
  // System domain: pin and request synchronisers
  // ----------------------------------------------------------------
  logic wp_s1_q;
  logic wp_s2_q;
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  logic req_new;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_s1_q  <= 1'b1;
      wp_s2_q  <= 1'b1;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      wp_s1_q  <= wp_n;
      wp_s2_q  <= wp_s1_q;
      tgl_s1_q <= req_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  assign req_new = tgl_s2_q ^ tgl_s3_q;

  // ----------------------------------------------------------------
  // System domain: request capture
  // ----------------------------------------------------------------
  // Payload taken once, while the link side holds it steady, so the
  // decode below never reads flops of the other clock.
  spl_pkg::spl_cmd_s cmd_q;
  logic              cmd_vld_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_q     <= '{kind: spl_pkg::CMD_NONE, data: 8'h00, sector: '0};
      cmd_vld_q <= 1'b0;
    end else begin
      cmd_vld_q <= req_new;
      if (req_new) begin
        cmd_q <= req_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // System domain: lock decode
  // ----------------------------------------------------------------
  logic       wp_eff_n;
  logic       lock_q;
  logic [3:0] glob_sel;

  assign wp_eff_n = octal_mode | wp_s2_q;
  assign hw_lock  = ~wp_eff_n & lock_q;
  assign glob_sel = cmd_q.data[spl_pkg::GLOB_MSB:spl_pkg::GLOB_LSB];

  // Only the lock bit is stored from a status write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_q <= spl_pkg::LOCK_RST;
    end else if (cmd_vld_q && cmd_q.kind == spl_pkg::CMD_WSR && !hw_lock) begin
      lock_q <= cmd_q.data[spl_pkg::LOCK_BIT];
    end
  end

  // ----------------------------------------------------------------
  // System domain: sector protection bits
  // ----------------------------------------------------------------
  logic [spl_pkg::NUM_SECTORS-1:0] prot_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prot_q <= spl_pkg::PROT_RST;
    end else if (cmd_vld_q && !lock_q) begin
      case (cmd_q.kind)
        spl_pkg::CMD_WSR: begin
          // Global action with the lock clear, also when setting it
          if (glob_sel == spl_pkg::GLOB_UNPROT) begin
            prot_q <= '0;
          end else if (glob_sel == spl_pkg::GLOB_PROT) begin
            prot_q <= '1;
          end
        end
        spl_pkg::CMD_PROT: begin
          prot_q[cmd_q.sector] <= 1'b1;
        end
        spl_pkg::CMD_UNPROT: begin
          prot_q[cmd_q.sector] <= 1'b0;
        end
        default: begin
          prot_q <= prot_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // System domain: status presented to the host and user
  // ----------------------------------------------------------------
  logic [7:0] status_d;
  logic [7:0] status_q;
  logic [1:0] summary_q;

  always_comb begin
    status_d = 8'h00;
    status_d[spl_pkg::LOCK_BIT]    = lock_q;
    status_d[spl_pkg::STAT_WP_BIT] = wp_eff_n;
    status_d[spl_pkg::STAT_SUM_LSB +: 2] = prot_summary(prot_q);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q  <= 8'h00;
      summary_q <= spl_pkg::SUM_ALL;
    end else begin
      status_q  <= status_d;
      summary_q <= prot_summary(prot_q);
    end
  end

  assign sector_prot                 = prot_q;
  assign protection_lock_bit         = lock_q;
  assign software_protection_summary = summary_q;
  assign status_byte                 = status_q;

endmodule
`default_nettype wire

// ==== dv/spl_lock_asserts.sv ====
// Concurrent checks on the ports of the sector protection lock logic
`default_nettype none
module spl_lock_asserts (
  input wire logic                            clk,                         // Clock
  input wire logic                            rst,                         // Reset
  input wire logic                            cs_n,                        // Select
  input wire logic                            so_oe,                       // Out enable
  input wire logic                            octal_mode,                  // Octal
  input wire logic [spl_pkg::NUM_SECTORS-1:0] sector_prot,                 // Bits
  input wire logic                            protection_lock_bit,         // Lock
  input wire logic                            hw_lock,                     // Hw lock
  input wire logic [1:0]                      software_protection_summary, // Summary
  input wire logic [7:0]                      status_byte                  // Status
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Four cycles held so no write launched before the lock can land
  sequence s_hw_held;
    hw_lock [*4];
  endsequence
  a_hw_lock_def: assert property (hw_lock |-> protection_lock_bit && !octal_mode)
    else $error("hw lock without lock bit or in octal mode");
  a_hw_freeze: assert property (s_hw_held |=> $stable(sector_prot) && $stable(protection_lock_bit))
    else $error("protection changed under hw lock");
  a_sum_code: assert property (software_protection_summary != 2'h2)
    else $error("summary code not defined");
  a_sum_track: assert property (software_protection_summary == (&$past(sector_prot) ? 2'h3 :
    (|$past(sector_prot) ? 2'h1 : 2'h0)))
    else $error("summary does not follow sector bits");
  a_status_fmt: assert property (status_byte[6:5] == 2'h0 && status_byte[1:0] == 2'h0)
    else $error("status unused bits set");
  a_status_lock: assert property (status_byte[7] == $past(protection_lock_bit))
    else $error("status bit 7 not lock bit");
  a_octal_pin: assert property (octal_mode && $past(octal_mode) && !$past(rst) |-> status_byte[4])
    else $error("pin not high in octal mode");
  a_oe_cs: assert property (cs_n |-> !so_oe)
    else $error("output driven without select");
  a_reset_val: assert property ($fell(rst) |-> &sector_prot && !protection_lock_bit && !hw_lock)
    else $error("bad state after reset");
endmodule
bind spl_lock spl_lock_asserts u_chk (
  .clk(clk), .rst(rst), .cs_n(cs_n), .so_oe(so_oe), .octal_mode(octal_mode),
  .sector_prot(sector_prot), .protection_lock_bit(protection_lock_bit), .hw_lock(hw_lock),
  .software_protection_summary(software_protection_summary), .status_byte(status_byte)
);
`default_nettype wire

// ==== dv/spl_host_model.sv ====
// Host controller model driving the serial command link
`default_nettype none
module spl_host_model (
  output logic      sck,   // Link clock, still between frames
  output logic      cs_n,  // Chip select, low
  output logic      si,    // Data to device
  input  wire logic so_o,  // Data from device
  input  wire logic so_oe  // Device drive enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Bit and frame tasks, 48 ns link period
  // ----------------------------------------------------------------
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end
  // Read bit taken just before the rise, half a period after it changed
  task automatic bit_x(input logic b, output logic r);
    si  = b;
    #24;
    r   = so_oe ? so_o : ~so_o; // Released line reads inverted
    sck = 1'b1;
    #24;
    sck = 1'b0;
  endtask
  task automatic tx8(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bit_x(b[i], r[i]);
  endtask
  task automatic start();
    cs_n = 1'b0;
    #24;
  endtask
  // Select may rise anywhere, data line left toggling once released
  task automatic stop();
    #24;
    cs_n = 1'b1;
    si   = ~si;
    #48;
  endtask
endmodule
`default_nettype wire

// ==== dv/sector_protection_lock_logic_tb.sv ====
// Self-checking bench for the sector protection lock logic
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) begin \
      err_count++; \
      $display("unexpected %s: expected %h seen %h", nm, ex, got); \
    end \
  end
module sector_protection_lock_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                            clk, rst, sck, cs_n, si, so_o, so_oe, wp_n, octal_mode;
  logic [spl_pkg::NUM_SECTORS-1:0] sector_prot;
  logic                            protection_lock_bit, hw_lock;
  logic [1:0]                      software_protection_summary;
  logic [7:0]                      status_byte, rd;
  int                              err_count = 0;
  int                              samples_checked = 0;
  spl_lock u_dut (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o),
    .so_oe(so_oe), .wp_n(wp_n), .octal_mode(octal_mode), .sector_prot(sector_prot),
    .protection_lock_bit(protection_lock_bit), .hw_lock(hw_lock),
    .software_protection_summary(software_protection_summary), .status_byte(status_byte));
  spl_host_model u_host (.sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic close_out();
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic st(input logic [15:0] p, input logic l);
    `CHK("state", {p, l}, {sector_prot, protection_lock_bit})
  endtask
  task automatic wsr(input logic [7:0] d);
    logic [7:0] r;
    u_host.start();
    u_host.tx8(spl_pkg::OP_WRITE_STATUS, r);
    u_host.tx8(d, r);
    u_host.stop();
    wait_clk(8);
  endtask
  // Reads one byte after the address when the opcode is a read
  task automatic adr(input logic [7:0] op, input logic [spl_pkg::SEC_W-1:0] s,
                     output logic [7:0] r);
    logic [31:0] a;
    a = 32'(s) << spl_pkg::SEC_LSB;
    u_host.start();
    u_host.tx8(op, r);
    for (int k = 3; k >= 0; k--) u_host.tx8(a[k*8 +: 8], r);
    if (op != spl_pkg::OP_PROTECT && op != spl_pkg::OP_UNPROTECT) u_host.tx8(8'h00, r);
    u_host.stop();
    wait_clk(8);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_global();
    wsr(8'h00);
    st(16'h0000, 1'b0);
    `CHK("status", 8'h10, status_byte)
    u_host.start();
    u_host.tx8(spl_pkg::OP_READ_STATUS, rd);
    u_host.tx8(8'h00, rd);
    u_host.stop();
    `CHK("status read", 8'h10, rd)
    adr(spl_pkg::OP_PROTECT, 4'h3, rd);
    st(16'h0008, 1'b0);
    `CHK("summary", 2'h1, software_protection_summary)
    adr(spl_pkg::OP_READ_PROT, 4'h3, rd);
    `CHK("prot read", 8'hff, rd)
    adr(spl_pkg::OP_READ_PROT, 4'h4, rd);
    `CHK("prot read", 8'h00, rd)
    wsr(8'hf0);
    st(16'h0008, 1'b1);
    adr(spl_pkg::OP_UNPROTECT, 4'h3, rd);
    st(16'h0008, 1'b1);
    wsr(8'h03);
    st(16'h0008, 1'b0);
    wsr(8'h7f);
    st(16'hffff, 1'b0);
    wsr(8'h80);
    st(16'h0000, 1'b1);
    wsr(8'h0f);
    st(16'h0000, 1'b0);
    wsr(8'hff);
    st(16'hffff, 1'b1);
  endtask
  task automatic t_hwlock();
    wp_n = 1'b0;
    wait_clk(4);
    `CHK("hw lock", 1'b1, hw_lock)
    `CHK("status", 8'h8c, status_byte)
    wsr(8'h00);
    st(16'hffff, 1'b1);
    adr(spl_pkg::OP_UNPROTECT, 4'h5, rd);
    st(16'hffff, 1'b1);
    rst = 1'b1;
    wait_clk(4);
    rst = 1'b0;
    wait_clk(4);
    st(16'hffff, 1'b0);
    `CHK("hw lock", 1'b0, hw_lock)
    wsr(8'hf0);
    `CHK("hw lock", 1'b1, hw_lock)
    adr(spl_pkg::OP_READ_PROT, 4'h1, rd);
    `CHK("prot read", 8'hff, rd)
    octal_mode = 1'b1;
    wait_clk(4);
    `CHK("hw lock", 1'b0, hw_lock)
    wsr(8'h0f);
    st(16'hffff, 1'b0);
    octal_mode = 1'b0;
    wp_n = 1'b1;
    wait_clk(4);
    // Unknown opcode with a data byte that would unprotect if decoded
    u_host.start();
    u_host.tx8(8'h00, rd);
    u_host.tx8(8'h00, rd);
    u_host.stop();
    wait_clk(8);
    st(16'hffff, 1'b0);
  endtask
  task automatic t_abort();
    logic b;
    u_host.start();
    u_host.tx8(spl_pkg::OP_READ_PROT, rd);
    for (int k = 0; k < 4; k++) u_host.tx8(8'h00, rd);
    `CHK("drive", 1'b1, so_oe)
    for (int k = 0; k < 3; k++) u_host.bit_x(1'b0, b);
    `CHK("mid byte bit", 1'b1, b)
    u_host.stop();
    `CHK("drive", 1'b0, so_oe)
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    octal_mode = 1'b0;
    wait_clk(4);
    rst = 1'b0;
    wait_clk(4);
    st(16'hffff, 1'b0);
    `CHK("status", 8'h1c, status_byte)
    t_global();
    t_hwlock();
    t_abort();
    close_out();
  end
  initial begin
    #1000000;
    err_count++;
    close_out();
  end
endmodule
`default_nettype wire
